/* src/embedded_ram_rdw.sv */
`timescale 1ns/100ps
module embedded_ram_rdw
  import ram_rdw_pkg::*;
(
  input wire logic I_CLK_SYS, // 200 MHz system clock
  input wire logic I_RST_N, // synchronous reset, active low
  input wire logic [1:0] I_BLOCK_TYPE, // large, medium or logic-array
  input wire logic [1:0] I_PORT_MODE, // single, simple or true dual-port
  input wire logic I_SP_NEW, // same-port: 1 new data, 0 don't care
  input wire logic [1:0] I_MP_MODE, // mixed-port output mode
  input wire logic I_OUTREG_A, // port A output register used
  input wire logic I_OUTREG_B, // port B output register used
  input wire logic I_INIT_WE, // preload write strobe
  input wire logic [`RDW_ADDR_W-1:0] I_INIT_ADDR, // preload address
  input wire logic [`RDW_DATA_W-1:0] I_INIT_DATA, // preload word
  input wire logic I_WREN_A, // port A write enable
  input wire logic I_RDEN_A, // port A read enable
  input wire logic [`RDW_ADDR_W-1:0] I_ADDR_A, // port A address
  input wire logic [`RDW_DATA_W-1:0] I_WDATA_A, // port A write data
  input wire logic I_WREN_B, // port B write enable
  input wire logic I_RDEN_B, // port B read enable
  input wire logic [`RDW_ADDR_W-1:0] I_ADDR_B, // port B address
  input wire logic [`RDW_DATA_W-1:0] I_WDATA_B, // port B write data
  output logic [`RDW_DATA_W-1:0] O_Q_A, // port A read data
  output logic O_UNKNOWN_A, // port A data is a don't-care value
  output logic [`RDW_DATA_W-1:0] O_Q_B, // port B read data
  output logic O_UNKNOWN_B, // port B data is a don't-care value
  output logic O_WR_CLASH, // both ports wrote one address last cycle
  output logic O_MODE_ILLEGAL // mode set not offered by this block type
);
  ram_word_type mem_ff [`RDW_DEPTH];
  logic clash_ff;
  logic illegal_ff;

  wire is_large = (I_BLOCK_TYPE == `RDW_BLK_LARGE);
  wire is_medium = (I_BLOCK_TYPE == `RDW_BLK_MEDIUM);
  wire is_logic = (I_BLOCK_TYPE == `RDW_BLK_LOGIC);
  wire mode_single = (I_PORT_MODE == `RDW_PORT_SINGLE);
  wire mode_simple = (I_PORT_MODE == `RDW_PORT_SIMPLE);
  wire mode_true = (I_PORT_MODE == `RDW_PORT_TRUE);

  // port roles: single uses A only, simple writes on A and reads on B
  wire wr_a = I_WREN_A & (mode_single | mode_simple | mode_true);
  wire rd_a = I_RDEN_A & (mode_single | mode_true);
  wire wr_b = I_WREN_B & mode_true;
  wire rd_b = I_RDEN_B & (mode_simple | mode_true);

  wire same_addr = (I_ADDR_A == I_ADDR_B);
  // no arbitration: both writes go ahead, the kept word is not defined
  wire wr_clash = wr_a & wr_b & same_addr;
  // one system clock feeds both ports, so the mixed-port case is always in reach
  wire a_hit_by_b = wr_b & same_addr;
  wire b_hit_by_a = wr_a & same_addr;
  // a port writing the address it reads is the same-port case
  wire a_own = rd_a & wr_a;
  wire b_own = rd_b & wr_b;

  // logic-array RAM with bypassed output follows the array every cycle
  wire a_track = is_logic & ~I_OUTREG_A & (mode_single | mode_true);
  wire b_track = is_logic & ~I_OUTREG_B & (mode_simple | mode_true);

  // same-port new data: large always, medium when chosen; else don't care
  wire sp_new_ok = is_large | (is_medium & I_SP_NEW);

  wire mp_old = (I_MP_MODE == `RDW_MP_OLD);
  wire mp_new = (I_MP_MODE == `RDW_MP_NEW);
  wire mp_dc = (I_MP_MODE == `RDW_MP_DC);
  wire mp_cdc = (I_MP_MODE == `RDW_MP_CDC);

  // old word needs the registered path on the logic-array RAM
  wire old_ok_a = mp_old & ~(is_logic & ~I_OUTREG_A);
  wire old_ok_b = mp_old & ~(is_logic & ~I_OUTREG_B);
  wire new_ok_a = mp_new & is_logic & I_OUTREG_A;
  wire new_ok_b = mp_new & is_logic & I_OUTREG_B;

  // plain wires rather than a function, so a mode change alone re-decodes
  wire rd_any_a = rd_a | a_track;
  wire rd_any_b = rd_b | b_track;
  wire hit_sel_a = ~a_own & a_hit_by_b;
  wire hit_sel_b = ~b_own & b_hit_by_a;
  wire own_new_a = a_own & sp_new_ok;
  wire own_new_b = b_own & sp_new_ok;
  wire own_dc_a = a_own & ~sp_new_ok;
  wire own_dc_b = b_own & ~sp_new_ok;
  wire hit_new_a = hit_sel_a & new_ok_a;
  wire hit_new_b = hit_sel_b & new_ok_b;
  // don't care and constrained don't care both end here
  wire hit_dc_a = hit_sel_a & ~old_ok_a & ~new_ok_a;
  wire hit_dc_b = hit_sel_b & ~old_ok_b & ~new_ok_b;

  rd_src_type src_a;
  rd_src_type src_b;
  assign src_a = !rd_any_a ? SEL_IDLE :
                 own_new_a ? SEL_OWN :
                 hit_new_a ? SEL_OTHER :
                 (own_dc_a | hit_dc_a) ? SEL_UNKNOWN : SEL_MEM;
  assign src_b = !rd_any_b ? SEL_IDLE :
                 own_new_b ? SEL_OWN :
                 hit_new_b ? SEL_OTHER :
                 (own_dc_b | hit_dc_b) ? SEL_UNKNOWN : SEL_MEM;

  // array read happens before this edge's write lands, which gives old data
  wire ram_word_type mem_a = mem_ff[I_ADDR_A];
  wire ram_word_type mem_b = mem_ff[I_ADDR_B];

  ram_rd_if port_a_if ();
  ram_rd_if port_b_if ();

  assign port_a_if.rd_valid = (src_a != SEL_IDLE);
  assign port_a_if.sel_unknown = (src_a == SEL_UNKNOWN);
  assign port_a_if.use_outreg = I_OUTREG_A;
  assign port_a_if.sel_data = (src_a == SEL_OWN) ? I_WDATA_A :
                              (src_a == SEL_OTHER) ? I_WDATA_B :
                              (src_a == SEL_UNKNOWN) ? `RDW_DC_WORD : mem_a;

  assign port_b_if.rd_valid = (src_b != SEL_IDLE);
  assign port_b_if.sel_unknown = (src_b == SEL_UNKNOWN);
  assign port_b_if.use_outreg = I_OUTREG_B;
  assign port_b_if.sel_data = (src_b == SEL_OWN) ? I_WDATA_B :
                              (src_b == SEL_OTHER) ? I_WDATA_A :
                              (src_b == SEL_UNKNOWN) ? `RDW_DC_WORD : mem_b;

  ram_out_stage u_stage_a (
    .i_clk (I_CLK_SYS),
    .i_rst_n (I_RST_N),
    .rd (port_a_if.stage)
  );

  ram_out_stage u_stage_b (
    .i_clk (I_CLK_SYS),
    .i_rst_n (I_RST_N),
    .rd (port_b_if.stage)
  );

  // mode sets that the chosen block type does not offer
  wire sp_bad = is_large & ~I_SP_NEW;
  wire sp_logic_new = is_logic & I_SP_NEW;
  wire mp_bad_dedicated = ~is_logic & (mp_new | mp_cdc);
  wire mp_bad_logic_a = is_logic & (mp_new | mp_old) & ~I_OUTREG_A & mode_true;
  wire mp_bad_logic_b = is_logic & (mp_new | mp_old) & ~I_OUTREG_B & ~mode_single;
  wire blk_bad = ~(is_large | is_medium | is_logic);
  wire port_bad = ~(mode_single | mode_simple | mode_true);
  wire nxt_illegal = sp_bad | sp_logic_new | mp_bad_dedicated | mp_bad_logic_a |
                     mp_bad_logic_b | blk_bad | port_bad;
  wire unused_mp = mp_dc;

  // array: cleared at reset so an unloaded array reads zero, then preload
  // writes take the array ahead of both ports in the same cycle
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      for (int i = 0; i < `RDW_DEPTH; i++) begin
        mem_ff[i] <= `RDW_ZERO_WORD;
      end
    end else if (I_INIT_WE) begin
      mem_ff[I_INIT_ADDR] <= I_INIT_DATA;
    end else begin
      if (wr_b) begin
        mem_ff[I_ADDR_B] <= I_WDATA_B;
      end
      // on a clash port A lands last; the user logic must not rely on it
      if (wr_a) begin
        mem_ff[I_ADDR_A] <= I_WDATA_A;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      clash_ff <= 1'b0;
      illegal_ff <= 1'b0;
    end else begin
      clash_ff <= wr_clash & ~I_INIT_WE;
      illegal_ff <= nxt_illegal | (unused_mp & 1'b0);
    end
  end

  assign O_Q_A = port_a_if.q;
  assign O_UNKNOWN_A = port_a_if.q_unknown;
  assign O_Q_B = port_b_if.q;
  assign O_UNKNOWN_B = port_b_if.q_unknown;
  assign O_WR_CLASH = clash_ff;
  assign O_MODE_ILLEGAL = illegal_ff;
endmodule // embedded_ram_rdw

/* include/ram_rdw_defs.svh */
// Notes on behaviour
// - in true dual-port mode both ports may write one address in the same cycle, with no arbitration, and the stored word is then not defined.
// - same-port read-during-write handling applies to the single port, and to each port of a true dual-port RAM that reads the address it writes.
// - in same-port new-data mode the large and medium dedicated RAMs show the word being written at the edge that writes it.
// - in same-port don't-care mode the medium dedicated RAM and the logic-array RAM may show any value on a same-port read-during-write.
// - mixed-port read-during-write handling applies in simple and true dual-port modes when one port reads the address the other writes on one clock.
// - mixed-port new-data mode exists only for the registered logic-array RAM and shows the new word on the edge after the write.
// - mixed-port old-data mode returns the word held before the write, and the logic-array RAM allows it only with a registered output.
// - in mixed-port don't-care and constrained don't-care modes a read of the address being written returns an unknown value.
// - a mixed-port read-during-write is supported only when both ports share one input clock, and otherwise its read result counts as unknown.
// - at power-up the logic-array RAM drives zero with output registers used and the current contents at the read address with them bypassed.
// - the large and medium dedicated RAMs power up with cleared outputs, registered or bypassed, even with a preloaded array.
// - every RAM can be preloaded, and without a preload every cell starts at zero.
// - the logic-array RAM has only data input and output registers at its edge, keeps write address and read data registers inside, and takes read address registering from neighbouring logic.
`ifndef RAM_RDW_DEFS_SVH
`define RAM_RDW_DEFS_SVH

`define RDW_DATA_W 20
`define RDW_ADDR_W 5
`define RDW_DEPTH 32

`define RDW_BLK_LARGE 2'h0
`define RDW_BLK_MEDIUM 2'h1
`define RDW_BLK_LOGIC 2'h2

`define RDW_PORT_SINGLE 2'h0
`define RDW_PORT_SIMPLE 2'h1
`define RDW_PORT_TRUE 2'h2

`define RDW_MP_OLD 2'h0
`define RDW_MP_NEW 2'h1
`define RDW_MP_DC 2'h2
`define RDW_MP_CDC 2'h3

`define RDW_ZERO_WORD 20'h00000
`define RDW_DC_WORD 20'h00000

`endif

/* include/ram_rdw_pkg.sv */
`include "ram_rdw_defs.svh"

package ram_rdw_pkg;
  typedef logic [`RDW_DATA_W-1:0] ram_word_type;
  typedef logic [`RDW_ADDR_W-1:0] ram_addr_type;
  typedef enum logic [2:0] {
    SEL_IDLE,
    SEL_MEM,
    SEL_OWN,
    SEL_OTHER,
    SEL_UNKNOWN
  } rd_src_type;
endpackage

/* include/ram_rd_if.sv */
`timescale 1ns/100ps
interface ram_rd_if;
  import ram_rdw_pkg::*;
  logic rd_valid;
  ram_word_type sel_data;
  logic sel_unknown;
  logic use_outreg;
  ram_word_type q;
  logic q_unknown;

  modport core (
    output rd_valid,
    output sel_data,
    output sel_unknown,
    output use_outreg,
    input q,
    input q_unknown
  );
  modport stage (
    input rd_valid,
    input sel_data,
    input sel_unknown,
    input use_outreg,
    output q,
    output q_unknown
  );
endinterface

/* src/ram_out_stage.sv */
`timescale 1ns/100ps
module ram_out_stage
  import ram_rdw_pkg::*;
(
  input wire logic i_clk, // system clock
  input wire logic i_rst_n, // synchronous reset, active low
  ram_rd_if.stage rd // read value in, port output out
);
  ram_word_type data_ff;
  logic unk_ff;
  ram_word_type q_ff;
  logic q_unk_ff;

  // internal read data register; cleared so outputs power up at zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      data_ff <= `RDW_ZERO_WORD;
      unk_ff <= 1'b0;
    end else if (rd.rd_valid) begin
      data_ff <= rd.sel_data;
      unk_ff <= rd.sel_unknown;
    end
  end

  // registered output adds one edge; bypass loads the read value directly
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q_ff <= `RDW_ZERO_WORD;
      q_unk_ff <= 1'b0;
    end else if (rd.use_outreg) begin
      q_ff <= data_ff;
      q_unk_ff <= unk_ff;
    end else if (rd.rd_valid) begin
      q_ff <= rd.sel_data;
      q_unk_ff <= rd.sel_unknown;
    end
  end

  assign rd.q = q_ff;
  assign rd.q_unknown = q_unk_ff;
endmodule // ram_out_stage

/* testbench/embedded_ram_rdw_assertions.sv */
`timescale 1ns/100ps
`include "ram_rdw_defs.svh"
module embedded_ram_rdw_assertions (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire logic [1:0] I_BLOCK_TYPE,
  input wire logic [1:0] I_PORT_MODE,
  input wire logic [1:0] I_MP_MODE,
  input wire logic I_OUTREG_A,
  input wire logic I_OUTREG_B,
  input wire logic I_INIT_WE,
  input wire logic I_WREN_A,
  input wire logic I_RDEN_A,
  input wire logic [`RDW_ADDR_W-1:0] I_ADDR_A,
  input wire logic [`RDW_DATA_W-1:0] I_WDATA_A,
  input wire logic I_WREN_B,
  input wire logic I_RDEN_B,
  input wire logic [`RDW_ADDR_W-1:0] I_ADDR_B,
  input wire logic [`RDW_DATA_W-1:0] O_Q_A,
  input wire logic O_UNKNOWN_A,
  input wire logic [`RDW_DATA_W-1:0] O_Q_B,
  input wire logic O_UNKNOWN_B,
  input wire logic O_WR_CLASH,
  input wire logic O_MODE_ILLEGAL
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  wire same = I_ADDR_A == I_ADDR_B;
  wire clash = I_PORT_MODE == 2'h2 && I_WREN_A && I_WREN_B && same;
  // port mode 0 or 2: port A is the active reader
  wire sp_a = !I_PORT_MODE[0] && !I_OUTREG_A && I_WREN_A && I_RDEN_A && !I_INIT_WE;
  wire mx_b = I_PORT_MODE == 2'h1 && I_WREN_A && I_RDEN_B && same && !I_OUTREG_B && !I_INIT_WE;
  property p_clash;
    clash && !I_INIT_WE |=> O_WR_CLASH;
  endproperty
  a_clash: assert property (p_clash) else $error("clash not flagged");
  property p_clash_src;
    O_WR_CLASH |-> $past(clash);
  endproperty
  a_clash_src: assert property (p_clash_src) else $error("clash without cause");
  property p_sp_new;
    sp_a && I_BLOCK_TYPE == 2'h0 |=> !O_UNKNOWN_A && O_Q_A == $past(I_WDATA_A);
  endproperty
  a_sp_new: assert property (p_sp_new) else $error("new data missing");
  property p_sp_dc;
    sp_a && I_BLOCK_TYPE == 2'h2 |=> O_UNKNOWN_A;
  endproperty
  a_sp_dc: assert property (p_sp_dc) else $error("dont care not flagged");
  property p_mp_dc;
    mx_b && I_MP_MODE[1] && I_BLOCK_TYPE != 2'h3 |=> O_UNKNOWN_B && O_Q_B == 20'h00000;
  endproperty
  a_mp_dc: assert property (p_mp_dc) else $error("mixed unknown missing");
  property p_mp_old;
    mx_b && I_MP_MODE == 2'h0 && !I_BLOCK_TYPE[1] |=> !O_UNKNOWN_B;
  endproperty
  a_mp_old: assert property (p_mp_old) else $error("old data flagged");
  property p_bad;
    I_BLOCK_TYPE != 2'h2 && I_MP_MODE == 2'h1 || I_BLOCK_TYPE == 2'h3 |=> O_MODE_ILLEGAL;
  endproperty
  a_bad: assert property (p_bad) else $error("illegal mode missed");
  property p_pwr;
    $rose(I_RST_N) |-> O_Q_A == 20'h00000 && O_Q_B == 20'h00000 && !O_WR_CLASH;
  endproperty
  a_pwr: assert property (p_pwr) else $error("outputs not cleared");
  c_clash: cover property (clash);
  c_mx: cover property (mx_b);
  c_sp: cover property (sp_a);
endmodule // embedded_ram_rdw_assertions
bind embedded_ram_rdw embedded_ram_rdw_assertions chk (.*);

/* testbench/ram_user_model.sv */
`timescale 1ns/100ps
module ram_user_model (
  input wire logic i_wr_a, // port A write request
  input wire logic i_wr_b, // port B write request
  input wire logic i_same, // true mode, both ports on one word
  input wire logic i_allow, // let a clash through on purpose
  output logic o_wr_b // port B write as issued
);
  // a held-back write is dropped, not retried: callers must not rely on it
  assign o_wr_b = i_wr_b && (i_allow || !(i_wr_a && i_same));
endmodule // ram_user_model

/* testbench/embedded_ram_rdw_bench.sv */
`timescale 1ns/100ps
`include "ram_rdw_defs.svh"
module embedded_ram_rdw_bench;
  import ram_rdw_pkg::*;
  logic clk = 0, rst_n = 0, sp = 0, oa = 0, ob = 0, we = 0, wa = 0, ra = 0, wb = 0, rb = 0;
  logic ok = 0, wbg, ua, ub, wc, il;
  logic [1:0] blk = 2'h0, pm = 2'h2, mp = 2'h0;
  ram_addr_type aa = 0, ab = 0;
  ram_word_type da = 0, db = 0, qa, qb;
  logic [31:0] seed = 32'hd454b187;
  int mem[32], failures = 0, tests_run = 0, cyc = 0;
  embedded_ram_rdw dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_BLOCK_TYPE(blk),
    .I_PORT_MODE(pm), .I_SP_NEW(sp), .I_MP_MODE(mp), .I_OUTREG_A(oa), .I_OUTREG_B(ob),
    .I_INIT_WE(we), .I_INIT_ADDR(aa), .I_INIT_DATA(da), .I_WREN_A(wa), .I_RDEN_A(ra),
    .I_ADDR_A(aa), .I_WDATA_A(da), .I_WREN_B(wbg), .I_RDEN_B(rb), .I_ADDR_B(ab),
    .I_WDATA_B(db), .O_Q_A(qa), .O_UNKNOWN_A(ua), .O_Q_B(qb), .O_UNKNOWN_B(ub),
    .O_WR_CLASH(wc), .O_MODE_ILLEGAL(il));
  ram_user_model user (.i_wr_a(wa), .i_wr_b(wb), .i_same(aa == ab && pm == 2'h2),
    .i_allow(ok), .o_wr_b(wbg));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end
  task finish_test();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task check(input logic [20:0] seen, input logic [20:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function logic [20:0] rdv(bit own, bit oth, int ad, ram_word_type w, bit orr);
    if (own) return (blk == 0 || (blk == 1 && sp)) ? {1'b0, w} : 21'h100000;
    if (!oth || (mp == 0 && (blk != 2 || orr))) return {1'b0, ram_word_type'(mem[ad])};
    if (mp == 1 && blk == 2 && orr) return {1'b0, w};
    return 21'h100000;
  endfunction
  function bit bad_mode();
    if (blk == 3 || pm == 3) return 1'b1;
    if ((blk == 0 && !sp) || (blk == 2 && sp)) return 1'b1;
    if (blk != 2) return mp == 1 || mp == 3;
    return mp < 2 && ((pm == 2 && !oa) || (pm != 0 && !ob));
  endfunction
  task op(input bit w_a, r_a, w_b, r_b, input int x, y);
    bit ca, cb, ha, hb, wwa, wwb;
    int la, lb;
    logic [20:0] ea, eb;
    @(posedge clk);
    {wa, ra, wb, rb} <= {w_a, r_a, w_b, r_b};
    aa <= ram_addr_type'(x);
    ab <= ram_addr_type'(y);
    da <= ram_word_type'(rnd());
    db <= ram_word_type'(rnd());
    #1;
    wwa = wa;
    wwb = wbg && pm == 2;
    ha = wwb && aa == ab;
    hb = wwa && aa == ab;
    ca = pm != 1 && (ra || (blk == 2 && !oa && !wwa));
    cb = pm != 0 && (rb || (blk == 2 && !ob && !wwb));
    ea = rdv(wwa, ha, aa, wwa ? da : db, oa);
    eb = rdv(wwb, hb, ab, wwb ? db : da, ob);
    la = 1 + oa;
    lb = 1 + ob;
    for (int k = 1; k < 4; k++) begin
      @(posedge clk);
      if (k == 1) begin
        {wa, ra, wb, rb} <= 4'h0;
        if (wwb) mem[ab] = db;
        if (wwa) mem[aa] = da;
      end
      #1;
      if (k == 1) check({20'h00000, wc}, {20'h00000, wwa && ha});
      if (ca && la == k) check({ua, qa}, ea);
      if (cb && lb == k) check({ub, qb}, eb);
    end
  endtask
  task init(input int x, input int d);
    @(posedge clk);
    we <= 1'b1;
    aa <= ram_addr_type'(x);
    da <= ram_word_type'(d);
    @(posedge clk);
    we <= 1'b0;
    mem[x] = d;
  endtask
  initial begin
    logic [31:0] r;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) op(0, 1, 0, 1, i, i + 4);
    for (int i = 0; i < 4; i++) init(i, int'(rnd() & 32'h000fffff));
    for (int c = 0; c < 36; c++) begin
      @(posedge clk);
      {blk, pm, mp} <= {2'(c / 12), 2'(c / 4 % 3), 2'(c % 4)};
      {sp, oa, ob} <= 3'(rnd());
      repeat (2) @(posedge clk);
      #1;
      check({20'h00000, il}, {20'h00000, bad_mode()});
      for (int n = 0; n < 12; n++) begin
        r = rnd();
        op(r[0], r[1], r[2], r[3], r[5:4], r[7:6]);
      end
    end
    @(posedge clk);
    ok <= 1'b1;
    op(1, 0, 1, 0, 3, 3);
    ok <= 1'b0;
    op(0, 1, 0, 1, 3, 3);
    @(posedge clk);
    blk <= 2'h3;
    repeat (2) @(posedge clk);
    #1;
    check({20'h00000, il}, {20'h00000, bad_mode()});
    @(posedge clk);
    rst_n <= 1'b0;
    mem = '{default: 0};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    blk <= 2'h0;
    op(0, 1, 0, 1, 3, 3);
    finish_test();
  end
endmodule // embedded_ram_rdw_bench
